// file: rtl/bst_pkg.sv
// Package: constants and types for the boundary-scan test port
`default_nettype none
package bst_pkg;
  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int          IR_W          = 10;
  localparam logic [9:0]  IR_SAMPLE     = 10'h005;
  localparam logic [9:0]  IR_EXTEST     = 10'h00F;
  localparam logic [9:0]  IR_BYPASS     = 10'h3FF;
  localparam logic [9:0]  IR_CAPTURE    = 10'h001;
  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int          TLR_TMS_COUNT = 5;
  localparam int          CELL_BITS     = 3;
  localparam int          PIN_COUNT     = 8;
  localparam logic [2:0]  CNT_ZERO      = 3'h0;
  localparam logic [2:0]  CNT_ONE       = 3'h1;
  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR    = 4'h0,
    ST_RTI    = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'hA,
    ST_SH_IR  = 4'hB,
    ST_EX1_IR = 4'hC,
    ST_PAU_IR = 4'hD,
    ST_EX2_IR = 4'hE,
    ST_UPD_IR = 4'hF
  } bst_state_e;
endpackage : bst_pkg
`default_nettype wire

// file: rtl/bst_chain_if.sv
// Interface: controller to boundary chain signals
`default_nettype none
interface bst_chain_if #(parameter int N = 8);
  logic         capture;
  logic         shift;
  logic         update;
  logic         sdi;
  logic         sdo;
  logic [N-1:0] cap_out;
  logic [N-1:0] cap_oe;
  logic [N-1:0] cap_in;
  logic [N-1:0] upd_out;
  logic [N-1:0] upd_oe;
  modport ctrl  (output capture, shift, update, sdi, cap_out, cap_oe, cap_in,
                 input sdo, upd_out, upd_oe);
  modport chain (input capture, shift, update, sdi, cap_out, cap_oe, cap_in,
                 output sdo, upd_out, upd_oe);
endinterface : bst_chain_if
`default_nettype wire

// file: rtl/bst_chain.sv
// Boundary-scan register: one serial chain of three-bit pin cells
`default_nettype none
module bst_chain
  import bst_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input  wire logic  tck_in,      // Test clock
  input  wire logic  reset_n_in,  // Async reset, active low
  bst_chain_if.chain bus          // Controls from the controller
);
  localparam int L = CELL_BITS * N;

  logic [L-1:0] chain_reg;
  logic [N-1:0] upd_out_reg;
  logic [N-1:0] upd_oe_reg;

  // ----------------------------------------------------------------
  // Capture and shift
  // ----------------------------------------------------------------
  // Cell i: bit 3i input, 3i+1 enable, 3i+2 output; bit 0 faces serial out
  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chain_reg <= '0;
    end else if (bus.capture) begin
      for (int i = 0; i < N; i++) begin
        chain_reg[CELL_BITS*i]   <= bus.cap_in[i];
        chain_reg[CELL_BITS*i+1] <= bus.cap_oe[i];
        chain_reg[CELL_BITS*i+2] <= bus.cap_out[i];
      end
    end else if (bus.shift) begin
      chain_reg <= {bus.sdi, chain_reg[L-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // Update stage
  // ----------------------------------------------------------------
  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      upd_out_reg <= '0;
      upd_oe_reg  <= '0;
    end else if (bus.update) begin
      for (int i = 0; i < N; i++) begin
        upd_oe_reg[i]  <= chain_reg[CELL_BITS*i+1];
        upd_out_reg[i] <= chain_reg[CELL_BITS*i+2];
      end
    end
  end

  assign bus.sdo     = chain_reg[0];
  assign bus.upd_out = upd_out_reg;
  assign bus.upd_oe  = upd_oe_reg;

  chk_chain_shift: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    bus.shift && !bus.capture |=> chain_reg[L-1] == $past(bus.sdi)
      && chain_reg[L-2:0] == $past(chain_reg[L-1:1]))
    else $error("chain did not shift by one");
  chk_cell_capture: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    bus.capture |=> chain_reg[0] == $past(bus.cap_in[0])
      && chain_reg[2] == $past(bus.cap_out[0]))
    else $error("cell capture wrong");
endmodule : bst_chain
`default_nettype wire

// file: rtl/bst_tap.sv
// Boundary-scan test port: controller, instruction, bypass, pin muxing
`default_nettype none
module bst_tap
  import bst_pkg::*;
#(
  parameter int N = PIN_COUNT
) (
  input  wire logic         clk_sys_in,      // System clock, 20 MHz
  input  wire logic         reset_n_in,      // Async reset, active low
  input  wire logic         tck_in,          // Test clock
  input  wire logic         tms_in,          // Test mode select
  input  wire logic         tdi_in,          // Test data in
  output logic              tdo_out,         // Test data out
  output logic              tdo_oe_out,      // Test data out enable
  input  wire logic         config_busy_in,  // Configuration through test port
  input  wire logic [N-1:0] core_out_in,     // Core output data per pin
  input  wire logic [N-1:0] core_oe_in,      // Core output enable per pin
  input  wire logic [N-1:0] pin_in,          // Pad input level per pin
  output logic      [N-1:0] pin_out_out,     // Pad output data
  output logic      [N-1:0] pin_oe_out       // Pad output enable
);
  // Only tck_in, tms_in, tdi_in, tdo_out and tdo_oe_out reach the test port

  bst_state_e     state_reg;
  bst_state_e     state_next;
  logic [IR_W-1:0] ir_shift_reg;
  logic [IR_W-1:0] ir_reg;
  logic           bypass_reg;
  logic           bsr_sel;
  logic           shifting;
  logic [N-1:0]   pin_s1_reg, pin_s2_reg;
  logic [N-1:0]   cout_s1_reg, cout_s2_reg;
  logic [N-1:0]   coe_s1_reg, coe_s2_reg;

  bst_chain_if #(.N(N)) cbus ();

  function automatic logic sel_boundary(input logic [IR_W-1:0] ir);
    return (ir == IR_SAMPLE) || (ir == IR_EXTEST);
  endfunction : sel_boundary

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------
  always_comb begin
    case (state_reg)
      ST_TLR:    state_next = tms_in ? ST_TLR    : ST_RTI;
      ST_RTI:    state_next = tms_in ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: state_next = tms_in ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_next = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  state_next = tms_in ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: state_next = tms_in ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: state_next = tms_in ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: state_next = tms_in ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: state_next = tms_in ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: state_next = tms_in ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: state_next = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  state_next = tms_in ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: state_next = tms_in ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: state_next = tms_in ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: state_next = tms_in ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: state_next = tms_in ? ST_SEL_DR : ST_RTI;
      default:   state_next = ST_TLR;
    endcase
  end

  // TMS and TDI are launched by the tester on falling TCK, so no sync
  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_shift_reg <= IR_CAPTURE;
    end else if (state_reg == ST_CAP_IR) begin
      ir_shift_reg <= IR_CAPTURE;
    end else if (state_reg == ST_SH_IR) begin
      ir_shift_reg <= {tdi_in, ir_shift_reg[IR_W-1:1]};
    end
  end

  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ir_reg <= IR_BYPASS;
    end else if (state_reg == ST_TLR) begin
      ir_reg <= IR_BYPASS;
    end else if (state_reg == ST_UPD_IR) begin
      ir_reg <= ir_shift_reg;
    end
  end

  assign bsr_sel = sel_boundary(ir_reg);

  // ----------------------------------------------------------------
  // Bypass register and boundary chain controls
  // ----------------------------------------------------------------
  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bypass_reg <= 1'b0;
    end else if (state_reg == ST_CAP_DR) begin
      bypass_reg <= 1'b0;
    end else if (state_reg == ST_SH_DR) begin
      bypass_reg <= tdi_in;
    end
  end

  // Core and pad levels are foreign to TCK: two stages before capture
  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_reg  <= '0;
      pin_s2_reg  <= '0;
      cout_s1_reg <= '0;
      cout_s2_reg <= '0;
      coe_s1_reg  <= '0;
      coe_s2_reg  <= '0;
    end else begin
      pin_s1_reg  <= pin_in;
      pin_s2_reg  <= pin_s1_reg;
      cout_s1_reg <= core_out_in;
      cout_s2_reg <= cout_s1_reg;
      coe_s1_reg  <= core_oe_in;
      coe_s2_reg  <= coe_s1_reg;
    end
  end

  assign cbus.capture = bsr_sel && (state_reg == ST_CAP_DR);
  assign cbus.shift   = bsr_sel && (state_reg == ST_SH_DR);
  assign cbus.update  = bsr_sel && (state_reg == ST_UPD_DR);
  assign cbus.sdi     = tdi_in;
  assign cbus.cap_in  = pin_s2_reg;
  assign cbus.cap_out = cout_s2_reg;
  assign cbus.cap_oe  = coe_s2_reg;

  bst_chain #(.N(N)) u_chain (
    .tck_in     (tck_in),
    .reset_n_in (reset_n_in),
    .bus        (cbus)
  );

  // ----------------------------------------------------------------
  // Serial output on falling TCK
  // ----------------------------------------------------------------
  assign shifting = (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);

  always_ff @(negedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else begin
      tdo_oe_out <= shifting;
      if (state_reg == ST_SH_IR) begin
        tdo_out <= ir_shift_reg[0];
      end else if (state_reg == ST_SH_DR) begin
        tdo_out <= bsr_sel ? cbus.sdo : bypass_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Update words to the system clock: toggle handshake
  // ----------------------------------------------------------------
  // TCK may outrun the system clock, so a word is held until acknowledged
  logic [N-1:0] xfer_out_reg, xfer_oe_reg;
  logic         req_tgl_reg, ack_t1_reg, ack_t2_reg, ack_tgl_reg;
  logic         extest_reg;

  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      extest_reg <= 1'b0;
    end else if (state_reg == ST_TLR) begin
      extest_reg <= 1'b0;
    end else if (state_reg == ST_UPD_IR) begin
      // Decoded on the same edge as the instruction: TCK may stop right after
      extest_reg <= (ir_shift_reg == IR_EXTEST);
    end
  end

  always_ff @(posedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_t1_reg <= 1'b0;
      ack_t2_reg <= 1'b0;
    end else begin
      ack_t1_reg <= ack_tgl_reg;
      ack_t2_reg <= ack_t1_reg;
    end
  end

  // Launched on falling TCK, so the word leaves in the cycle after Update-DR
  // even if the tester stops TCK there; a word changed while one is in flight
  // waits for the acknowledge, which needs two more rising TCK edges
  always_ff @(negedge tck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_tgl_reg  <= 1'b0;
      xfer_out_reg <= '0;
      xfer_oe_reg  <= '0;
    end else if (req_tgl_reg == ack_t2_reg
                 && (cbus.upd_out != xfer_out_reg || cbus.upd_oe != xfer_oe_reg)) begin
      xfer_out_reg <= cbus.upd_out;
      xfer_oe_reg  <= cbus.upd_oe;
      req_tgl_reg  <= ~req_tgl_reg;
    end
  end

  // ----------------------------------------------------------------
  // System clock side: pad drivers
  // ----------------------------------------------------------------
  logic         req_s1_reg, req_s2_reg;
  logic         ext_s1_reg, ext_s2_reg;
  logic [N-1:0] hold_out_reg, hold_oe_reg;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      ext_s1_reg <= extest_reg;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_tgl_reg  <= 1'b0;
      hold_out_reg <= '0;
      hold_oe_reg  <= '0;
    end else if (req_s2_reg != ack_tgl_reg) begin
      hold_out_reg <= xfer_out_reg;
      hold_oe_reg  <= xfer_oe_reg;
      ack_tgl_reg  <= req_s2_reg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_out_out <= '0;
      pin_oe_out  <= '0;
    end else if (config_busy_in) begin
      pin_out_out <= '0;
      pin_oe_out  <= '0;
    end else if (ext_s2_reg) begin
      pin_out_out <= hold_out_reg;
      pin_oe_out  <= hold_oe_reg;
    end else begin
      pin_out_out <= core_out_in;
      pin_oe_out  <= core_oe_in;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_five_tms_reset: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    tms_in [*5] |=> state_reg == ST_TLR)
    else $error("five TMS highs did not reach reset state");
  chk_reset_bypass: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    state_reg == ST_TLR |=> ir_reg == IR_BYPASS)
    else $error("reset state did not load bypass");
  chk_ir_shift_in: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    state_reg == ST_SH_IR |=> ir_shift_reg[IR_W-1] == $past(tdi_in))
    else $error("instruction bit not taken from TDI");
  chk_ir_load: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    state_reg == ST_UPD_IR |=> ir_reg == $past(ir_shift_reg))
    else $error("instruction not loaded at update");
  // Output stage runs on falling TCK, so a rising edge sees the state it served
  chk_tdo_release: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    tdo_oe_out == shifting)
    else $error("TDO enable does not follow shifting");
  chk_tdo_ir_bit: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    state_reg == ST_SH_IR |-> tdo_out == ir_shift_reg[0])
    else $error("TDO not the instruction low bit");
  chk_bypass_path: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    state_reg == ST_SH_DR && !bsr_sel ##1 state_reg == ST_SH_DR
      |-> tdo_out == $past(tdi_in))
    else $error("bypass path is not one bit");
  chk_dr_select: assert property (@(posedge tck_in) disable iff (!reset_n_in)
    state_reg == ST_UPD_IR && (ir_shift_reg == IR_SAMPLE || ir_shift_reg == IR_EXTEST)
      |=> bsr_sel)
    else $error("boundary code did not select chain");
  chk_config_hiz: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    config_busy_in |=> pin_oe_out == '0)
    else $error("pins driven during configuration");

  cov_load_extest: cover property (@(posedge tck_in) disable iff (!reset_n_in)
    state_reg == ST_UPD_IR && ir_shift_reg == IR_EXTEST);
  cov_bsr_shift: cover property (@(posedge tck_in) disable iff (!reset_n_in)
    cbus.shift [*3]);
  cov_pins_driven: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ext_s2_reg && !config_busy_in);
endmodule : bst_tap
`default_nettype wire

// file: bench/bst_tester_model.sv
// Behavioural model of the external boundary-scan tester
`default_nettype none
module bst_tester_model (
  output logic        tck_out,        // Test clock, runs only while the cycle task runs
  output logic        tms_out,        // Mode select
  output logic        tdi_out,        // Serial data to the device
  input  wire logic   tdo_in,         // Serial data from the device
  input  wire logic   tdo_oe_in,      // Device drives the data-out line
  output logic        res_valid_out,  // Pulse when a scan result is ready
  output logic [31:0] res_data_out    // Bits shifted out, first bit at bit 0
);
  timeunit 1ns;
  timeprecision 100ps;

  logic tdo_last;

  initial begin
    tck_out       = 1'h0;
    tms_out       = 1'h1;
    tdi_out       = 1'h1;
    res_valid_out = 1'h0;
    res_data_out  = 32'h0;
    tdo_last      = 1'h0;
  end

  // ----------------------------------------------------------------
  // One test clock period of 15 ns
  // ----------------------------------------------------------------
  task automatic cycle(input logic tms, input logic tdi, output logic tdo);
    #1;
    tms_out = tms;
    tdi_out = tdi;
    #6.5;
    // A released line shows no stale level, so a lost enable is caught
    tdo      = tdo_oe_in ? tdo_in : ~tdo_last;
    tdo_last = tdo;
    tck_out  = 1'h1;
    #7.5;
    tck_out  = 1'h0;
  endtask : cycle

  task automatic tap_reset();
    logic d;
    repeat (5) cycle(1'h1, 1'h1, d);
    cycle(1'h0, 1'h1, d);
    tms_out = 1'h1;
  endtask : tap_reset

  // From idle: shift width bits, finish in idle, report what came out
  task automatic scan(input logic is_ir, input int width, input logic [31:0] din);
    logic        d;
    logic [31:0] dout;
    dout = 32'h0;
    cycle(1'h1, 1'h1, d);
    if (is_ir) begin
      cycle(1'h1, 1'h1, d);
    end
    cycle(1'h0, 1'h1, d);
    cycle(1'h0, 1'h1, d);
    for (int i = 0; i < width; i++) begin
      cycle(i == width - 1, din[i], d);
      dout[i] = d;
    end
    cycle(1'h1, 1'h1, d);
    cycle(1'h0, 1'h1, d);
    tms_out       = 1'h1;
    res_data_out  = dout;
    res_valid_out = 1'h1;
    #1;
    res_valid_out = 1'h0;
  endtask : scan
endmodule : bst_tester_model
`default_nettype wire

// file: bench/bst_tap_bench.sv
// Self-checking testbench for the boundary-scan test port
`default_nettype none
module bst_tap_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import bst_pkg::*;

  logic                 clk_sys_in;
  logic                 reset_n_in;
  logic                 tck;
  logic                 tms;
  logic                 tdi;
  logic                 tdo;
  logic                 tdo_oe;
  logic                 config_busy_in;
  logic [PIN_COUNT-1:0] core_out_in;
  logic [PIN_COUNT-1:0] core_oe_in;
  logic [PIN_COUNT-1:0] pin_in;
  logic [PIN_COUNT-1:0] pin_out_out;
  logic [PIN_COUNT-1:0] pin_oe_out;
  logic                 res_valid;
  logic [31:0]          res_data;
  logic                 pin_strobe;
  logic [31:0]          exp_q[$];
  int                   error_cnt;
  int                   checked;
  int                   seed;

  bst_tap dut (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .config_busy_in(config_busy_in),
    .core_out_in(core_out_in), .core_oe_in(core_oe_in), .pin_in(pin_in),
    .pin_out_out(pin_out_out), .pin_oe_out(pin_oe_out));

  bst_tester_model tester (
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo), .tdo_oe_in(tdo_oe),
    .res_valid_out(res_valid), .res_data_out(res_data));

  always #25 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------------------------------
  // Expected values and shared steps
  // ----------------------------------------------------------------
  function automatic logic [23:0] cap_word();
    logic [23:0] w;
    for (int i = 0; i < PIN_COUNT; i++) begin
      w[3*i]   = pin_in[i];
      w[3*i+1] = core_oe_in[i];
      w[3*i+2] = core_out_in[i];
    end
    return w;
  endfunction : cap_word

  function automatic logic [15:0] upd_word(input logic [23:0] p);
    logic [15:0] w;
    for (int i = 0; i < PIN_COUNT; i++) begin
      w[8+i] = p[3*i+1];
      w[i]   = p[3*i+2];
    end
    return w;
  endfunction : upd_word

  task automatic load_ir(input logic [9:0] code);
    exp_q.push_back({22'h0, IR_CAPTURE});
    tester.scan(1'h1, IR_W, {22'h0, code});
  endtask : load_ir

  task automatic bypass_check();
    logic [7:0] d;
    d = 8'($random(seed));
    exp_q.push_back({24'h0, d[6:0], 1'h0});
    tester.scan(1'h0, 8, {24'h0, d});
  endtask : bypass_check

  // Idle port must leave the data-out line released
  task automatic check_pins(input logic [15:0] oe_out);
    repeat (10) @(negedge clk_sys_in);
    exp_q.push_back({15'h0, 1'h0, oe_out});
    pin_strobe = 1'h1;
    @(negedge clk_sys_in);
    pin_strobe = 1'h0;
  endtask : check_pins

  task automatic final_report();
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Monitor: each result is matched against the oldest note
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] got;
    logic [31:0] exp;
    forever begin
      @(posedge res_valid or posedge pin_strobe);
      got = pin_strobe ? {15'h0, tdo_oe, pin_oe_out, pin_out_out} : res_data;
      exp = 32'hFFFF_FFFF;
      if (exp_q.size() != 0) begin
        exp = exp_q.pop_front();
      end
      checked++;
      if (got !== exp) begin
        error_cnt++;
        $display("mismatch at %0t: expected %0h got %0h", $time, exp, got);
      end
    end
  end

  initial begin
    #200000;
    error_cnt++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [23:0] pat;
    logic [23:0] pat2;
    logic [9:0]  code;
    logic        b;
    seed           = 52;
    clk_sys_in     = 1'h0;
    reset_n_in     = 1'h0;
    config_busy_in = 1'h0;
    core_out_in    = 8'h00;
    core_oe_in     = 8'h00;
    pin_in         = 8'h00;
    pin_strobe     = 1'h0;
    error_cnt      = 0;
    checked        = 0;
    tester.tap_reset();
    repeat (20) @(negedge clk_sys_in);
    reset_n_in = 1'h1;
    tester.tap_reset();
    bypass_check();
    @(negedge clk_sys_in);
    core_out_in = 8'($random(seed));
    core_oe_in  = 8'($random(seed));
    pin_in      = 8'($random(seed));
    load_ir(IR_SAMPLE);
    pat = 24'($random(seed));
    exp_q.push_back({8'h0, cap_word()});
    tester.scan(1'h0, CELL_BITS * PIN_COUNT, {8'h0, pat});
    check_pins({core_oe_in, core_out_in});
    load_ir(IR_EXTEST);
    check_pins(upd_word(pat));
    pat2 = 24'($random(seed));
    exp_q.push_back({8'h0, cap_word()});
    tester.scan(1'h0, CELL_BITS * PIN_COUNT, {8'h0, pat2});
    check_pins(upd_word(pat2));
    @(negedge clk_sys_in);
    config_busy_in = 1'h1;
    check_pins(16'h0000);
    config_busy_in = 1'h0;
    check_pins(upd_word(pat2));
    for (int k = 0; k < 4; k++) begin
      code = (k == 0) ? IR_BYPASS : 10'($random(seed));
      if (code == IR_SAMPLE || code == IR_EXTEST) begin
        code = IR_BYPASS;
      end
      load_ir(code);
      bypass_check();
      check_pins({core_oe_in, core_out_in});
    end
    // Abandon a boundary shift midway; five highs must still recover
    load_ir(IR_EXTEST);
    tester.cycle(1'h1, 1'h1, b);
    tester.cycle(1'h0, 1'h1, b);
    tester.cycle(1'h0, 1'h1, b);
    repeat (3) tester.cycle(1'h0, 1'h0, b);
    tester.tap_reset();
    bypass_check();
    check_pins({core_oe_in, core_out_in});
    final_report();
  end
endmodule : bst_tap_bench
`default_nettype wire
